// ==== src/core_perf_state_control.sv ====
// Per-core performance-state controller with its MSR access port.
// Notes on behaviour
// - Sixteen states 0..15 exist, 0 fastest, higher numbers slower.
// - Each core has its own request, limit and status; writes touch one.
// - Cores sharing a plane may end in a state other than requested.
// - Limit register bits 7:4 report the slowest supported state.
// - Limit register bits 3:0 report the fastest state now allowed.
// - A request above the supported maximum is stored as that maximum.
// - On a limit change the core goes to the slower of request and limit.
// - Status bits 3:0 report the present state as its plain number.
// - Status only moves once the frequency has reached the new state.
// - Writes to limit or status fault and leave them unchanged.
// - Bit 7 of the capability word advertises hardware state control.
// - Reset values of max, limit, request and present are parameters.
`timescale 1ns/1ps
`include "perf_state_regs.svh"
module core_perf_state_control #(
  parameter int unsigned NUM_CORES     = 2,
  parameter bit          SHARED_PLANE  = 1'b0,
  parameter logic [3:0]  MAX_STATE_RST = `PS_MAX_STATE_RST,
  parameter logic [3:0]  LIMIT_RST     = `PS_LIMIT_RST,
  parameter logic [3:0]  REQUEST_RST   = `PS_REQUEST_RST,
  parameter logic [3:0]  PRESENT_RST   = `PS_PRESENT_RST
)(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_n_i,
  input  wire core_perf_state_pkg::msr_req_t msr_req_i,
  output core_perf_state_pkg::msr_rsp_t      msr_rsp_o,
  input  wire logic [NUM_CORES-1:0][3:0]     current_state_limit_i,
  output logic [NUM_CORES-1:0][3:0]          freq_sel_o,
  output logic [NUM_CORES-1:0][3:0]          present_state_number_o,
  output logic [31:0]                        perf_cap_word_o
);

  typedef struct packed {
    logic [NUM_CORES-1:0][3:0]     req;
    logic [3:0]                    max_state_number;
    core_perf_state_pkg::msr_rsp_t rsp;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic [NUM_CORES-1:0][3:0] limit_w;
  logic [NUM_CORES-1:0][3:0] target_w;
  logic [NUM_CORES-1:0][3:0] goal_w;
  logic [NUM_CORES-1:0][3:0] present_w;
  logic [3:0]                slowest;
  logic [7:0]                core_idx;
  logic                      core_ok;
  logic                      is_limit;
  logic                      is_req;
  logic                      is_status;
  logic                      req_wr;
  logic                      ro_wr;
  logic [3:0]                clip_wr;
  logic [3:0]                sel_limit;
  logic [3:0]                sel_present;
  logic [3:0]                sel_req;

  assign core_idx = msr_req_i.core;
  assign core_ok = msr_req_i.valid &&
                   (32'(core_idx) < NUM_CORES);
  assign is_limit = (msr_req_i.addr == `PS_LIMIT_MSR);
  assign is_req = (msr_req_i.addr == `PS_REQUEST_MSR);
  assign is_status = (msr_req_i.addr == `PS_STATUS_MSR);
  assign req_wr = core_ok && msr_req_i.write && is_req;
  assign ro_wr = core_ok && msr_req_i.write && (is_limit || is_status);

  // Only the low nibble is looked at; the reserved bits are dropped.
  assign clip_wr = core_perf_state_pkg::smaller(
    msr_req_i.wdata[`PS_STATE_MSB:`PS_STATE_LSB],
    s_q.max_state_number);

  // An out-of-range core index reads as zero and is never used below,
  // because every access with it faults.
  always_comb
  begin
    sel_limit = 4'h0;
    sel_present = 4'h0;
    sel_req = 4'h0;
    for (int k = 0; k < NUM_CORES; k++)
    begin
      if (32'(core_idx) == k)
      begin
        sel_limit = limit_w[k];
        sel_present = present_w[k];
        sel_req = s_q.req[k];
      end
    end
  end

  // With a shared plane the slowest target wins, which keeps every core
  // inside its own limit at the price of the faster requests.
  always_comb
  begin
    slowest = 4'h0;
    for (int k = 0; k < NUM_CORES; k++)
    begin
      slowest = core_perf_state_pkg::larger(slowest, target_w[k]);
    end
    for (int k = 0; k < NUM_CORES; k++)
    begin
      goal_w[k] = SHARED_PLANE ? slowest : target_w[k];
    end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.rsp = '0;
    if (msr_req_i.valid)
    begin
      s_d.rsp.done = 1'b1;
      if (!core_ok)
      begin
        s_d.rsp.general_protection_fault = 1'b1;
      end
      else if (is_limit)
      begin
        if (msr_req_i.write)
        begin
          s_d.rsp.general_protection_fault = 1'b1;
        end
        else
        begin
          s_d.rsp.rdata[`PS_MAXVAL_MSB:`PS_MAXVAL_LSB] =
            s_q.max_state_number;
          s_d.rsp.rdata[`PS_STATE_MSB:`PS_STATE_LSB] =
            sel_limit;
        end
      end
      else if (is_req)
      begin
        if (msr_req_i.write)
        begin
          for (int k = 0; k < NUM_CORES; k++)
          begin
            if (32'(core_idx) == k)
            begin
              s_d.req[k] = clip_wr;
            end
          end
        end
        else
        begin
          s_d.rsp.rdata[`PS_STATE_MSB:`PS_STATE_LSB] = sel_req;
        end
      end
      else if (is_status)
      begin
        if (msr_req_i.write)
        begin
          s_d.rsp.general_protection_fault = 1'b1;
        end
        else
        begin
          s_d.rsp.rdata[`PS_STATE_MSB:`PS_STATE_LSB] =
            sel_present;
        end
      end
      else
      begin
        s_d.rsp.general_protection_fault = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int k = 0; k < NUM_CORES; k++)
      begin
        s_q.req[k] <= REQUEST_RST;
      end
      s_q.max_state_number <= MAX_STATE_RST;
      s_q.rsp <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  for (genvar k = 0; k < NUM_CORES; k++)
  begin : g_core
    perf_target_select #(
      .LIMIT_RST (LIMIT_RST)
    ) u_select (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .req_i     (s_q.req[k]),
      .max_i     (s_q.max_state_number),
      .limit_i   (current_state_limit_i[k]),
      .limit_o   (limit_w[k]),
      .target_o  (target_w[k])
    );

    freq_transition #(
      .PRESENT_RST (PRESENT_RST)
    ) u_transition (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .target_i   (goal_w[k]),
      .freq_sel_o (freq_sel_o[k]),
      .present_o  (present_w[k])
    );

    chk_core_isolated: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !(req_wr && 32'(core_idx) == k) |=> $stable(s_q.req[k]))
      else $error("Request of one core changed by another access.");

    chk_state_range: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      s_q.req[k] <= s_q.max_state_number)
      else $error("Stored request beyond the slowest state.");

    // A core may end slower than it asked, never faster than any target
    // that its plane has to honour.
    chk_shared_plane: assert property (
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      goal_w[k] >= target_w[k] &&
        (!SHARED_PLANE || goal_w[k] >= target_w[(k + 1) % NUM_CORES]))
      else $error("Core goal is faster than a target it must honour.");
  end

  assign present_state_number_o = present_w;
  assign msr_rsp_o = s_q.rsp;
  assign perf_cap_word_o = 32'h1 << `PS_CAP_HW_CTRL_BIT;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence read_s;
    core_ok && !msr_req_i.write;
  endsequence

  chk_req_clip: assert property (
    req_wr |=> s_q.req[$past(core_idx)] == $past(clip_wr))
    else $error("Request not stored clipped to the maximum.");

  chk_ro_fault: assert property (
    ro_wr |=> msr_rsp_o.done && msr_rsp_o.general_protection_fault)
    else $error("Write to a read-only register did not fault.");

  chk_max_report: assert property (
    (read_s ##0 is_limit) |=>
      msr_rsp_o.rdata[7:4] == s_q.max_state_number)
    else $error("Limit read lost the maximum state field.");

  chk_limit_report: assert property (
    (read_s ##0 is_limit) |=> msr_rsp_o.rdata[3:0] == $past(sel_limit))
    else $error("Limit read lost the current limit field.");

  chk_status_report: assert property (
    (read_s ##0 is_status) |=>
      msr_rsp_o.rdata[3:0] == $past(sel_present))
    else $error("Status read does not show the present state.");

  chk_reserved_zero: assert property (
    msr_rsp_o.done |-> msr_rsp_o.rdata[63:8] == 56'h0)
    else $error("Reserved read bits are not zero.");

  chk_cap_bit: assert property (
    perf_cap_word_o[7] && $countones(perf_cap_word_o) == 1)
    else $error("Capability word does not advertise state control.");

  chk_done_pulse: assert property (
    msr_req_i.valid |=> msr_rsp_o.done)
    else $error("Access was not answered in the next cycle.");

  // Every refused access answers with a fault and no data, so software
  // never mistakes a refused read for a state of zero.
  sequence fault_answer_s;
    msr_rsp_o.done && msr_rsp_o.general_protection_fault &&
      msr_rsp_o.rdata == 64'h0;
  endsequence

  sequence good_answer_s;
    msr_rsp_o.done && !msr_rsp_o.general_protection_fault;
  endsequence

  chk_bad_core: assert property (
    (msr_req_i.valid && !core_ok) |=> fault_answer_s)
    else $error("Access to a missing core was not refused.");

  chk_ro_refused: assert property (
    ro_wr |=> fault_answer_s)
    else $error("Read-only write was answered with data.");

  chk_ro_no_effect: assert property (
    ro_wr |=> $stable(s_q.req))
    else $error("Read-only write changed a stored request.");

  chk_write_taken: assert property (
    req_wr |=> good_answer_s ##0 msr_rsp_o.rdata == 64'h0)
    else $error("Request write was not acknowledged cleanly.");

  chk_req_readback: assert property (
    (read_s ##0 is_req) |=>
      good_answer_s ##0 msr_rsp_o.rdata == 64'($past(sel_req)))
    else $error("Request read does not return the stored value.");

  chk_status_upper: assert property (
    (read_s ##0 is_status) |=> msr_rsp_o.rdata[63:4] == 60'h0)
    else $error("Status read shows data above the state field.");

  chk_max_fixed: assert property (
    $stable(s_q.max_state_number))
    else $error("Slowest supported state moved while running.");
endmodule

// ==== src/core_perf_state_pkg.sv ====
// Types and helper functions shared by the perf-state block.
package core_perf_state_pkg;

  typedef logic [3:0] perf_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  core;
    logic [31:0] addr;
    logic [63:0] wdata;
  } msr_req_t;

  typedef struct packed {
    logic        done;
    logic        general_protection_fault;
    logic [63:0] rdata;
  } msr_rsp_t;

  function automatic perf_state_t larger(perf_state_t a, perf_state_t b);
    return (a > b) ? a : b;
  endfunction

  function automatic perf_state_t smaller(perf_state_t a, perf_state_t b);
    return (a < b) ? a : b;
  endfunction

endpackage

// ==== src/freq_transition.sv ====
// Per-core frequency transition sequencer and present-state holder.
`timescale 1ns/1ps
`include "perf_state_regs.svh"
module freq_transition #(
  parameter logic [3:0] PRESENT_RST = `PS_PRESENT_RST
)(
  input  wire logic                             clk_sys_i,
  input  wire logic                             reset_n_i,
  input  wire core_perf_state_pkg::perf_state_t target_i,
  output core_perf_state_pkg::perf_state_t      freq_sel_o,
  output core_perf_state_pkg::perf_state_t      present_o
);
  localparam int unsigned RELOCK_CYC = `PS_RELOCK_CYC;
  localparam logic [11:0] CNT_LOAD = 12'(RELOCK_CYC - 1);

  typedef struct packed {
    logic        busy;
    logic [11:0] cnt;
    logic [3:0]  sel;
    logic [3:0]  present;
  } xfer_state_t;

  xfer_state_t s_q;
  xfer_state_t s_d;

  // A new target is only taken once the clock has settled, so the
  // generator never sees a second step during relock.
  always_comb
  begin
    s_d = s_q;
    if (!s_q.busy)
    begin
      if (target_i != s_q.present)
      begin
        s_d.busy = 1'b1;
        s_d.sel = target_i;
        s_d.cnt = CNT_LOAD;
      end
    end
    else if (s_q.cnt == 12'h000)
    begin
      s_d.busy = 1'b0;
      s_d.present = s_q.sel;
    end
    else
    begin
      s_d.cnt = s_q.cnt - 12'h001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q.busy <= 1'b0;
      s_q.cnt <= 12'h000;
      s_q.sel <= PRESENT_RST;
      s_q.present <= PRESENT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign freq_sel_o = s_q.sel;
  assign present_o = s_q.present;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence settle_s;
    ##39 (s_q.busy && s_q.cnt == 12'h000) ##1 !s_q.busy;
  endsequence

  chk_settle_time: assert property (
    $rose(s_q.busy) |-> settle_s ##0 (s_q.present == s_q.sel))
    else $error("Present state not updated after relock time.");

  chk_present_hold: assert property (
    !(s_q.busy && s_q.cnt == 12'h000) |=> $stable(s_q.present))
    else $error("Present state moved before frequency settled.");
endmodule

// ==== src/perf_state_regs.svh ====
// Offsets, field positions, reset values and timing of the perf-state block.
`ifndef PERF_STATE_REGS_SVH
`define PERF_STATE_REGS_SVH
`define PS_LIMIT_MSR       32'hc0010061
`define PS_REQUEST_MSR     32'hc0010062
`define PS_STATUS_MSR      32'hc0010063
`define PS_STATE_LSB       0
`define PS_STATE_MSB       3
`define PS_MAXVAL_LSB      4
`define PS_MAXVAL_MSB      7
`define PS_CAP_HW_CTRL_BIT 7
`define PS_MAX_STATE_RST   4'hf
`define PS_LIMIT_RST       4'h0
`define PS_REQUEST_RST     4'h0
`define PS_PRESENT_RST     4'h0
`define PS_CLK_MHZ         20
`define PS_RELOCK_NS       2000
`define PS_RELOCK_CYC      ((`PS_RELOCK_NS * `PS_CLK_MHZ + 999) / 1000)
`endif

// ==== src/perf_target_select.sv ====
// Per-core limit tracking and target state selection.
`timescale 1ns/1ps
`include "perf_state_regs.svh"
module perf_target_select #(
  parameter logic [3:0] LIMIT_RST = `PS_LIMIT_RST
)(
  input  wire logic                             clk_sys_i,
  input  wire logic                             reset_n_i,
  input  wire core_perf_state_pkg::perf_state_t req_i,
  input  wire core_perf_state_pkg::perf_state_t max_i,
  input  wire core_perf_state_pkg::perf_state_t limit_i,
  output core_perf_state_pkg::perf_state_t      limit_o,
  output core_perf_state_pkg::perf_state_t      target_o
);
  typedef struct packed {
    logic [3:0] limit;
    logic [3:0] target;
  } sel_state_t;

  sel_state_t s_q;
  sel_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.limit = core_perf_state_pkg::smaller(limit_i, max_i);
    s_d.target = core_perf_state_pkg::larger(req_i, s_q.limit);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q.limit <= LIMIT_RST;
      s_q.target <= LIMIT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign limit_o = s_q.limit;
  assign target_o = s_q.target;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  chk_limit_floor: assert property (
    $changed(s_q.limit) |=> s_q.target ==
      core_perf_state_pkg::larger($past(req_i), $past(s_q.limit)))
    else $error("Target is not the slower of request and new limit.");
endmodule

// ==== testbench/tb.sv ====
// Self-checking testbench for the per-core performance-state controller.
`timescale 1ns/1ps
`include "perf_state_regs.svh"
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end

module tb;
  // A maximum below 15 so that clipping of requests and limits shows up.
  localparam logic [3:0] MAXS = 4'hc;

  typedef struct packed {
    logic        wr;
    logic [7:0]  core;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic        flt;
    logic [63:0] rdata;
  } row_t;

  logic                           clk_sys_i;
  logic                           reset_n_i;
  core_perf_state_pkg::msr_req_t  req;
  core_perf_state_pkg::msr_rsp_t  rsp;
  logic [1:0][3:0]                lim;
  logic [1:0][3:0]                fsel;
  logic [1:0][3:0]                pres;
  logic [1:0][3:0]                pres_sh;
  logic [31:0]                    cap;
  int                             error_cnt;
  int                             check_count;
  int                             cycles;
  int                             n;
  row_t                           rows [13];
  logic [63:0]                    rd;
  logic                           flt;

  core_perf_state_control #(
    .MAX_STATE_RST(MAXS)
  ) i_core_perf_state_control (
    .clk_sys_i              (clk_sys_i),
    .reset_n_i              (reset_n_i),
    .msr_req_i              (req),
    .msr_rsp_o              (rsp),
    .current_state_limit_i  (lim),
    .freq_sel_o             (fsel),
    .present_state_number_o (pres),
    .perf_cap_word_o        (cap)
  );

  // Same stimulus on a shared plane: both cores must follow the slowest.
  if (1'b1)
  begin : g_shared
    core_perf_state_control #(
      .SHARED_PLANE  (1'b1),
      .MAX_STATE_RST (MAXS)
    ) i_core_perf_state_control (
      .clk_sys_i              (clk_sys_i),
      .reset_n_i              (reset_n_i),
      .msr_req_i              (req),
      .msr_rsp_o              (),
      .current_state_limit_i  (lim),
      .freq_sel_o             (),
      .present_state_number_o (pres_sh),
      .perf_cap_word_o        ()
    );
  end

  task automatic results();
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The request is held through the taking edge; the answer lasts one cycle.
  task automatic access(input logic wr, input logic [7:0] core,
                        input logic [31:0] addr, input logic [63:0] wdata);
    @(posedge clk_sys_i);
    req <= '{valid: 1'b1, write: wr, core: core, addr: addr, wdata: wdata};
    @(posedge clk_sys_i);
    req.valid <= 1'b0;
    #1;
    `CHK(rsp.done, 1'b1);
    rd = rsp.rdata;
    flt = rsp.general_protection_fault;
  endtask

  task automatic wait_pres(input int c, input logic [3:0] v);
    for (n = 0; n < 100 && pres[c] !== v; n++)
      @(posedge clk_sys_i) #1;
    `CHK(pres[c], v);
    `CHK(fsel[c], v);
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Whole run needs well under a thousand cycles.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    reset_n_i = 1'b0;
    req = '0;
    lim = '0;
    error_cnt = 0;
    check_count = 0;
    cycles = 0;
    rows[0]  = '{1'b0, 8'h00, `PS_LIMIT_MSR, 64'h0, 1'b0, 64'hc0};
    rows[1]  = '{1'b1, 8'h00, `PS_REQUEST_MSR, 64'hffff_ffff_ffff_fff3,
                 1'b0, 64'h0};
    rows[2]  = '{1'b0, 8'h00, `PS_REQUEST_MSR, 64'h0, 1'b0, 64'h3};
    rows[3]  = '{1'b0, 8'h01, `PS_REQUEST_MSR, 64'h0, 1'b0, 64'h0};
    rows[4]  = '{1'b1, 8'h01, `PS_REQUEST_MSR, 64'hf, 1'b0, 64'h0};
    rows[5]  = '{1'b0, 8'h01, `PS_REQUEST_MSR, 64'h0, 1'b0, 64'hc};
    rows[6]  = '{1'b1, 8'h00, `PS_LIMIT_MSR, 64'h5, 1'b1, 64'h0};
    rows[7]  = '{1'b1, 8'h00, `PS_STATUS_MSR, 64'h5, 1'b1, 64'h0};
    rows[8]  = '{1'b0, 8'h00, `PS_STATUS_MSR, 64'h0, 1'b0, 64'h0};
    rows[9]  = '{1'b0, 8'h00, 32'hc0010064, 64'h0, 1'b1, 64'h0};
    rows[10] = '{1'b0, 8'h02, `PS_REQUEST_MSR, 64'h0, 1'b1, 64'h0};
    rows[11] = '{1'b0, 8'h01, `PS_LIMIT_MSR, 64'h0, 1'b0, 64'hc0};
    rows[12] = '{1'b0, 8'h00, `PS_LIMIT_MSR, 64'h0, 1'b0, 64'hc0};
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (rows[i])
    begin
      access(rows[i].wr, rows[i].core, rows[i].addr, rows[i].wdata);
      `CHK({flt, rd}, {rows[i].flt, rows[i].rdata});
    end
    `CHK(cap, 32'h0000_0080);
    wait_pres(0, 4'h3);
    wait_pres(1, MAXS);
    access(1'b0, 8'h00, `PS_STATUS_MSR, 64'h0);
    `CHK(rd, 64'h3);
    // Time from frequency select to reported state is the relock time.
    access(1'b1, 8'h00, `PS_REQUEST_MSR, 64'h7);
    for (n = 0; n < 10 && fsel[0] !== 4'h7; n++)
      @(posedge clk_sys_i) #1;
    for (n = 0; n < 100 && pres[0] !== 4'h7; n++)
    begin
      `CHK(pres[0], 4'h3);
      @(posedge clk_sys_i) #1;
    end
    `CHK(n, 40);
    @(posedge clk_sys_i) lim[0] <= 4'h9;
    wait_pres(0, 4'h9);
    access(1'b0, 8'h00, `PS_LIMIT_MSR, 64'h0);
    `CHK(rd, 64'hc9);
    @(posedge clk_sys_i) lim[0] <= 4'he;
    wait_pres(0, MAXS);
    access(1'b0, 8'h00, `PS_LIMIT_MSR, 64'h0);
    `CHK(rd, 64'hcc);
    @(posedge clk_sys_i) lim[0] <= 4'h0;
    wait_pres(0, 4'h7);
    `CHK(pres_sh, {MAXS, MAXS});
    @(posedge clk_sys_i) reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    `CHK(pres[0], 4'h0);
    reset_n_i <= 1'b1;
    access(1'b0, 8'h00, `PS_REQUEST_MSR, 64'h0);
    `CHK(rd, 64'h0);
    results();
  end
endmodule
